// File: hdl/vic_pkg.sv
// Purpose: constants and carrier types for the vectored interrupt controller
// Assumes: 32-bit Avalon-MM register access, full words only
// Notes:   offsets are byte addresses, each register one aligned word
//
// Operation
// R1: up to thirty-two maskable vectored sources, eight-level priority arbitration
// R2: drive active-low fast and normal request outputs toward the processor
// R3: internal sources are either level or edge; polarity does not matter
// R4: external sources: rising edge, falling edge, high level or low level
// R5: fast forcing routes a source to the fast request instead of normal
// R6: source 0 belongs to the fast input pin
// R7: source 1 is the OR of all system peripheral lines
// R8: priority logic covers sources 1..31, drives normal request, allows nesting
// R9: one 32-bit vector per source; vector read returns current vector
// R10: protect mode removes side effects of register reads
// R11: clocked continuously; no clock gating influences behaviour
// R12: either request output asserted wakes the processor from idle
// R13: general mask wakes the processor without asserting a request line
// R14: per-source trigger-type field selects each source's condition
// R15: enable and disable command writes, one access each; mask readable
// R16: a disabled source does not influence service of others
// R17: set and clear commands affect edge sources only, not level sources
// R18: vector read auto-clears the edge flag of the current source only
// R19: no auto-clear for fast-forced sources; they are purely fast
// R20: fast vector read auto-clears the edge flag of source 0
// R21: pending register shows activity of every source, masked or not
// R22: current number register and core status of both request lines
// R23: priorities 7 high to 0 low; ties go to lowest source number
// R24: during service only higher priority reasserts normal; others wait for end
// R25: vector read pushes level and number; end-of-service write pops
// R26: edge sources latch the edge until vector read or clear command
// R27: external inputs pass a two-stage synchroniser before detection
package vic_pkg;

  localparam int         NUM_SRC     = 32;
  localparam int         STACK_DEPTH = 8;
  localparam int         ADDR_W      = 9;

  localparam logic [8:0] OFS_MODE        = 9'h000;
  localparam logic [8:0] OFS_VECTOR_BASE = 9'h080;
  localparam logic [8:0] OFS_VECTOR      = 9'h100;
  localparam logic [8:0] OFS_FAST_VECTOR = 9'h104;
  localparam logic [8:0] OFS_CURRENT     = 9'h108;
  localparam logic [8:0] OFS_PENDING     = 9'h10C;
  localparam logic [8:0] OFS_MASK        = 9'h110;
  localparam logic [8:0] OFS_CORE_STATUS = 9'h114;
  localparam logic [8:0] OFS_ENABLE      = 9'h120;
  localparam logic [8:0] OFS_DISABLE     = 9'h124;
  localparam logic [8:0] OFS_CLEAR       = 9'h128;
  localparam logic [8:0] OFS_SET         = 9'h12C;
  localparam logic [8:0] OFS_END         = 9'h130;
  localparam logic [8:0] OFS_DEBUG       = 9'h138;
  localparam logic [8:0] OFS_FF_ENABLE   = 9'h140;
  localparam logic [8:0] OFS_FF_DISABLE  = 9'h144;
  localparam logic [8:0] OFS_FF_STATUS   = 9'h148;

  localparam int         PRIO_LSB     = 0;
  localparam int         PRIO_W       = 3;
  localparam int         TYPE_LSB     = 5;
  localparam int         TYPE_W       = 2;
  localparam logic [7:0] MODE_FIELDS  = 8'h67;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [31:0] VEC_RESET   = 32'h0000_0000;
  localparam logic [31:0] NORMAL_SRCS = 32'hFFFF_FFFE;
  localparam int         DBG_PROTECT  = 0;
  localparam int         DBG_GMASK    = 1;
  localparam int         CORE_NORMAL  = 0;
  localparam int         CORE_FAST    = 1;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [8:0]  address;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } avmm_rsp_t;

  typedef struct packed {
    logic [2:0] prio;
    logic [4:0] num;
  } stack_entry_t;

  typedef struct packed {
    logic [31:0][7:0]           mode;
    logic [31:0][31:0]          vec;
    logic [31:0]                mask;
    logic [31:0]                ffe;
    logic [31:0]                edge_flag;
    logic [31:0]                prev_lvl;
    logic [31:0]                sync1;
    logic [31:0]                sync2;
    stack_entry_t [7:0]         stack;
    logic [3:0]                 sp;
    logic                       protect;
    logic                       gmask;
    logic                       normal_n;
    logic                       fast_n;
    logic                       wake;
    avmm_rsp_t                  rsp;
  } state_t;

endpackage : vic_pkg

// File: hdl/vectored_interrupt_controller.sv
// Purpose: source control, priority, vectoring and request lines
// Assumes: i_clock free running; internal sources are on i_clock
// Notes:   one wait state on every bus access
`timescale 1ns/1ps
module vectored_interrupt_controller #(
  parameter int          SYSTEM_LINES = 4,
  parameter logic [31:0] EXTERNAL_MAP = 32'h0000_0005
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst_n,
  input  wire vic_pkg::avmm_req_t      i_bus,
  output vic_pkg::avmm_rsp_t           o_bus,
  input  wire logic                    i_fast_input_pin,
  input  wire logic [SYSTEM_LINES-1:0] i_system_source,
  input  wire logic [29:0]             i_sources,
  output logic                         o_normal_request_n,
  output logic                         o_fast_request_n,
  output logic                         o_wake
);
  import vic_pkg::*;

  state_t       state_q;
  state_t       state_d;
  logic [31:0]  raw;
  logic [31:0]  lvl;
  logic [31:0]  edge_mode;
  logic [31:0]  new_edge;
  logic [31:0]  active;
  logic [31:0]  enabled;
  logic [31:0]  set_cmd;
  logic [31:0]  clr_cmd;
  logic [31:0]  auto_clr;
  logic [8:0]   best;
  logic         found;
  logic [2:0]   bprio;
  logic [4:0]   bnum;
  stack_entry_t top;
  logic         normal_cond;
  logic         fast_cond;
  logic         first;
  logic         wr_acc;
  logic         rd_first;
  logic         vec_read;
  logic         fvec_read;
  logic [8:0]   addr;
  logic [4:0]   idx;
  logic [1:0]   typ;
  logic [31:0]  wd;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic in_region(input logic [8:0] a, input logic [8:0] base);
    return a[8:7] == base[8:7];
  endfunction : in_region

  // highest priority wins, strict compare keeps the lowest number on ties
  function automatic logic [8:0] pick(input logic [31:0] cand,
                                      input logic [31:0][7:0] mode);
    logic       f;
    logic [2:0] p;
    logic [4:0] n;
    f = 1'b0;
    p = 3'h0;
    n = 5'h00;
    for (int i = 1; i < NUM_SRC; i++) begin
      if (cand[i] && (!f || mode[i][PRIO_LSB +: PRIO_W] > p)) begin
        f = 1'b1;
        p = mode[i][PRIO_LSB +: PRIO_W];
        n = 5'(i);
      end
    end
    return {f, p, n};
  endfunction : pick

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    addr      = i_bus.address;
    wd        = i_bus.writedata;
    idx       = addr[6:2];
    first     = (i_bus.read | i_bus.write) & state_q.rsp.waitrequest;
    wr_acc    = i_bus.write & ~state_q.rsp.waitrequest;
    rd_first  = i_bus.read & first;
    set_cmd   = 32'h0000_0000;
    clr_cmd   = 32'h0000_0000;
    auto_clr  = 32'h0000_0000;
    lvl       = 32'h0000_0000;
    edge_mode = 32'h0000_0000;
    typ       = 2'h0;

    // source 1 gathers all system lines; polling finds the cause [R7]
    // source 0 is the fast input pin [R6]
    raw = {i_sources, |i_system_source, i_fast_input_pin};
    state_d.sync1 = raw;
    state_d.sync2 = state_q.sync1;

    for (int i = 0; i < NUM_SRC; i++) begin
      typ = state_q.mode[i][TYPE_LSB +: TYPE_W];
      // pins are read only after two stages; internal lines are on this clock [R27]
      // bit 1 of the type picks polarity for pins only [R3] [R4] [R14]
      if (EXTERNAL_MAP[i]) begin
        lvl[i] = typ[1] ? state_q.sync2[i] : ~state_q.sync2[i];
      end else begin
        lvl[i] = raw[i];
      end
      edge_mode[i] = typ[0];
    end

    new_edge = lvl & ~state_q.prev_lvl;
    state_d.prev_lvl = lvl;
    active  = (edge_mode & state_q.edge_flag) | (~edge_mode & lvl);
    enabled = active & state_q.mask; // [R16]

    // fast forced sources never enter arbitration [R5] [R8]
    best  = pick(enabled & ~state_q.ffe & NORMAL_SRCS, state_q.mode); // [R23] [R1]
    found = best[8];
    bprio = best[7:5];
    bnum  = best[4:0];
    top   = state_q.stack[3'(state_q.sp - 4'd1)];
    // only a level above the one in service may raise the line [R24]
    normal_cond = found && (state_q.sp == 4'd0 || bprio > top.prio);
    fast_cond   = enabled[0] | (|(enabled & state_q.ffe & NORMAL_SRCS)); // [R5]

    vec_read  = rd_first && addr == OFS_VECTOR && !state_q.protect; // [R10]
    fvec_read = rd_first && addr == OFS_FAST_VECTOR && !state_q.protect; // [R10]

    // ---------------------------------------------------------------
    // read data, captured in the wait cycle
    // ---------------------------------------------------------------
    if (rd_first) begin
      if (in_region(addr, OFS_MODE)) begin
        state_d.rsp.readdata = {24'h00_0000, state_q.mode[idx]};
      end else if (in_region(addr, OFS_VECTOR_BASE)) begin
        state_d.rsp.readdata = state_q.vec[idx];
      end else begin
        case (addr)
          OFS_VECTOR:      state_d.rsp.readdata = normal_cond ? state_q.vec[bnum] : VEC_RESET; // [R9]
          OFS_FAST_VECTOR: state_d.rsp.readdata = state_q.vec[0];
          OFS_CURRENT:     state_d.rsp.readdata = {27'h000_0000,
                                                   state_q.sp != 4'd0 ? top.num : 5'h00}; // [R22]
          OFS_PENDING:     state_d.rsp.readdata = active; // [R21]
          OFS_MASK:        state_d.rsp.readdata = state_q.mask; // [R15]
          OFS_CORE_STATUS: state_d.rsp.readdata = {30'h0000_0000,
                                                   ~state_q.fast_n, ~state_q.normal_n}; // [R22]
          OFS_DEBUG:       state_d.rsp.readdata = {30'h0000_0000,
                                                   state_q.gmask, state_q.protect};
          OFS_FF_STATUS:   state_d.rsp.readdata = state_q.ffe;
          default:         state_d.rsp.readdata = 32'h0000_0000;
        endcase
      end
    end

    // read side effects: push and auto-clear of the chosen source
    if (vec_read && normal_cond) begin
      if (state_q.sp < 4'(STACK_DEPTH)) begin
        state_d.stack[3'(state_q.sp)] = '{prio: bprio, num: bnum}; // [R25]
        state_d.sp = state_q.sp + 4'd1; // [R25]
      end
      // candidates exclude fast forced sources, so they are never cleared here [R19]
      auto_clr[bnum] = 1'b1; // [R18]
    end
    if (fvec_read) begin
      auto_clr[0] = 1'b1; // [R20]
    end

    // ---------------------------------------------------------------
    // writes, taken at the acknowledge edge
    // ---------------------------------------------------------------
    if (wr_acc) begin
      if (in_region(addr, OFS_MODE)) begin
        state_d.mode[idx] = wd[7:0] & MODE_FIELDS; // [R14]
      end else if (in_region(addr, OFS_VECTOR_BASE)) begin
        state_d.vec[idx] = wd; // [R9]
      end else begin
        case (addr)
          OFS_ENABLE:     state_d.mask = state_q.mask | wd; // [R15]
          OFS_DISABLE:    state_d.mask = state_q.mask & ~wd; // [R15]
          OFS_SET:        set_cmd = wd;
          OFS_CLEAR:      clr_cmd = wd;
          OFS_END: begin
            if (state_q.sp != 4'd0) begin
              state_d.sp = state_q.sp - 4'd1; // [R25] [R24]
            end
          end
          OFS_DEBUG: begin
            state_d.protect = wd[DBG_PROTECT];
            state_d.gmask   = wd[DBG_GMASK];
          end
          OFS_FF_ENABLE:  state_d.ffe = (state_q.ffe | wd) & NORMAL_SRCS;
          OFS_FF_DISABLE: state_d.ffe = state_q.ffe & ~wd;
          default:        state_d.ffe = state_q.ffe;
        endcase
      end
    end

    // edge memory; set wins over any clear, level sources keep it at zero
    state_d.edge_flag = edge_mode &
                        ((state_q.edge_flag & ~clr_cmd & ~auto_clr) | set_cmd | new_edge); // [R17] [R26]

    // general mask holds the lines off but still wakes the core [R13]
    state_d.normal_n = ~(normal_cond & ~state_q.gmask); // [R2] [R8]
    state_d.fast_n   = ~(fast_cond & ~state_q.gmask); // [R2]
    state_d.wake     = normal_cond | fast_cond; // [R12]

    state_d.rsp.waitrequest = ~first;
  end

  // ---------------------------------------------------------------
  // state register; no gating, runs on every rising edge
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin // [R11]
    if (!i_rst_n) begin
      state_q                 <= '0;
      state_q.mode            <= {NUM_SRC{MODE_RESET}};
      state_q.vec             <= {NUM_SRC{VEC_RESET}};
      state_q.normal_n        <= 1'b1;
      state_q.fast_n          <= 1'b1;
      state_q.rsp.waitrequest <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_bus              = state_q.rsp;
  assign o_normal_request_n = state_q.normal_n;
  assign o_fast_request_n   = state_q.fast_n;
  assign o_wake             = state_q.wake;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  property p_enable;
    (wr_acc && addr == OFS_ENABLE) |=> ((state_q.mask & $past(wd)) == $past(wd));
  endproperty
  a_enable: assert property (p_enable) // [R15]
    else $error("enable command did not set mask bits");

  property p_level_no_flag;
    ((state_q.edge_flag & ~edge_mode) == 32'h0000_0000) or
    ($past(edge_mode) != edge_mode);
  endproperty
  a_level_no_flag: assert property (p_level_no_flag) // [R17]
    else $error("edge flag held on a level source");

  property p_pending;
    rd_first && addr == OFS_PENDING |=> o_bus.readdata == $past(active) && !o_bus.waitrequest;
  endproperty
  a_pending: assert property (p_pending) // [R21]
    else $error("pending read does not show source activity");

  property p_core_status;
    rd_first && addr == OFS_CORE_STATUS |=>
      o_bus.readdata[1:0] == {~$past(o_fast_request_n), ~$past(o_normal_request_n)};
  endproperty
  a_core_status: assert property (p_core_status) // [R22]
    else $error("core status does not mirror request lines");

  property p_push;
    (vec_read && normal_cond && state_q.sp < 4'(STACK_DEPTH)) |=>
      state_q.sp == $past(state_q.sp) + 4'd1 && state_q.stack[3'($past(state_q.sp))].num == $past(bnum);
  endproperty
  a_push: assert property (p_push) // [R25]
    else $error("vector read did not push the current source");

  property p_protect;
    (rd_first && addr == OFS_VECTOR && state_q.protect) |=> state_q.sp == $past(state_q.sp);
  endproperty
  a_protect: assert property (p_protect) // [R10]
    else $error("protected vector read changed the stack");

  property p_fast_clear;
    (fvec_read && !new_edge[0]) |=> !state_q.edge_flag[0];
  endproperty
  a_fast_clear: assert property (p_fast_clear) // [R20]
    else $error("fast vector read left source 0 pending");

  property p_gmask;
    state_q.gmask |=> o_normal_request_n && o_fast_request_n;
  endproperty
  a_gmask: assert property (p_gmask) // [R13]
    else $error("request line asserted under general mask");

  property p_wake;
    (!o_normal_request_n || !o_fast_request_n) |-> o_wake;
  endproperty
  a_wake: assert property (p_wake) // [R12]
    else $error("request asserted without wake");

  property p_idle_lines;
    (!normal_cond && !fast_cond) |=> o_normal_request_n && o_fast_request_n && !o_wake;
  endproperty
  a_idle_lines: assert property (p_idle_lines) // [R2]
    else $error("request line asserted with no cause");

  property p_disable;
    (wr_acc && addr == OFS_DISABLE) |=> ((state_q.mask & $past(wd)) == 32'h0000_0000);
  endproperty
  a_disable: assert property (p_disable) // [R15]
    else $error("disable command left mask bits set");

  property p_pop;
    (wr_acc && addr == OFS_END && state_q.sp != 4'd0) |=> state_q.sp == $past(state_q.sp) - 4'd1;
  endproperty
  a_pop: assert property (p_pop) // [R25]
    else $error("end of service did not pop");

  property p_set_edge;
    (wr_acc && addr == OFS_SET) |=>
      ((state_q.edge_flag & $past(wd & edge_mode)) == $past(wd & edge_mode));
  endproperty
  a_set_edge: assert property (p_set_edge) // [R17]
    else $error("set command did not mark an edge source");

  property p_set_level;
    (wr_acc && addr == OFS_SET) |=> ((state_q.edge_flag & $past(wd & ~edge_mode)) == 32'h0000_0000);
  endproperty
  a_set_level: assert property (p_set_level) // [R17]
    else $error("set command marked a level source");

  property p_clear_edge;
    (wr_acc && addr == OFS_CLEAR) |=> ((state_q.edge_flag & $past(wd & ~new_edge)) == 32'h0000_0000);
  endproperty
  a_clear_edge: assert property (p_clear_edge) // [R17] [R26]
    else $error("clear command left a source pending");

  property p_auto_clear;
    (vec_read && normal_cond && !new_edge[bnum]) |=> !state_q.edge_flag[$past(bnum)];
  endproperty
  a_auto_clear: assert property (p_auto_clear) // [R18]
    else $error("vector read left the current source pending");

  property p_auto_other;
    (vec_read && normal_cond) |=>
      ((state_q.edge_flag & $past(state_q.edge_flag & edge_mode & ~(32'h0000_0001 << bnum))) ==
       $past(state_q.edge_flag & edge_mode & ~(32'h0000_0001 << bnum)));
  endproperty
  a_auto_other: assert property (p_auto_other) // [R18]
    else $error("vector read cleared another source");

  property p_mask_quiet;
    (state_q.mask == 32'h0000_0000) |=> o_normal_request_n && o_fast_request_n;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) // [R16]
    else $error("request line raised with all sources disabled");

  property p_nest_hold;
    (found && state_q.sp != 4'd0 && bprio <= top.prio) |=> o_normal_request_n;
  endproperty
  a_nest_hold: assert property (p_nest_hold) // [R24]
    else $error("normal line raised for a level not above service");

  property p_normal_raise;
    (normal_cond && !state_q.gmask) |=> !o_normal_request_n;
  endproperty
  a_normal_raise: assert property (p_normal_raise) // [R8]
    else $error("normal line not raised for an eligible source");

  property p_fast_raise;
    (fast_cond && !state_q.gmask) |=> !o_fast_request_n;
  endproperty
  a_fast_raise: assert property (p_fast_raise) // [R5]
    else $error("fast line not raised");

  property p_current_empty;
    (rd_first && addr == OFS_CURRENT && state_q.sp == 4'd0) |=> o_bus.readdata == 32'h0000_0000;
  endproperty
  a_current_empty: assert property (p_current_empty) // [R22]
    else $error("current number not zero with empty stack");

endmodule : vectored_interrupt_controller

// File: sim/core_model.sv
// Purpose: processor side of the request lines, counts handler entries
// Assumes: request lines are registered in the controller clock domain
// Notes:   an entry is a high-to-low step on a request line
`timescale 1ns/1ps
module core_model (
  input  wire logic       i_clock,
  input  wire logic       i_normal_request_n,
  input  wire logic       i_fast_request_n,
  output logic [7:0]      o_normal_entries,
  output logic [7:0]      o_fast_entries,
  output logic            o_awake
);
  logic normal_q;
  logic fast_q;
  initial begin
    {normal_q, fast_q, o_normal_entries, o_fast_entries, o_awake} = '0;
  end
  // both lines are active low; a low line is a request
  always @(posedge i_clock) begin
    normal_q <= i_normal_request_n;
    fast_q   <= i_fast_request_n;
    if (normal_q === 1'b1 && i_normal_request_n === 1'b0) begin
      o_normal_entries <= o_normal_entries + 8'h01;
    end
    if (fast_q === 1'b1 && i_fast_request_n === 1'b0) begin
      o_fast_entries <= o_fast_entries + 8'h01;
    end
    o_awake <= (i_normal_request_n === 1'b0) || (i_fast_request_n === 1'b0);
  end
endmodule : core_model

// File: sim/vectored_interrupt_controller_test.sv
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: one wait state per bus access, default source map
// Notes:   vector of source n, for n 0 to 8, is 0xA000_0000 plus n
`timescale 1ns/1ps
module vectored_interrupt_controller_test;
  import vic_pkg::*;
  typedef struct packed {logic wr; logic [8:0] a; logic [31:0] d;} row_t;
  localparam row_t ROWS [25] = '{
    '{1'b0, 9'h028, 32'h0000_0000}, '{1'b0, 9'h0A8, 32'h0000_0000}, '{1'b0, 9'h138, 32'h0000_0000},
    '{1'b1, 9'h024, 32'hFFFF_FFFF}, '{1'b0, 9'h024, 32'h0000_0067}, '{1'b1, 9'h000, 32'h0000_0060},
    '{1'b1, 9'h004, 32'h0000_0040}, '{1'b1, 9'h00C, 32'h0000_0042}, '{1'b0, 9'h00C, 32'h0000_0042},
    '{1'b1, 9'h010, 32'h0000_0065}, '{1'b1, 9'h014, 32'h0000_0040}, '{1'b1, 9'h018, 32'h0000_0060},
    '{1'b1, 9'h01C, 32'h0000_0063}, '{1'b1, 9'h020, 32'h0000_0063}, '{1'b1, 9'h120, 32'h0000_01DB},
    '{1'b0, 9'h110, 32'h0000_01DB}, '{1'b1, 9'h124, 32'h0000_0002}, '{1'b0, 9'h110, 32'h0000_01D9},
    '{1'b1, 9'h140, 32'h0000_0041}, '{1'b0, 9'h148, 32'h0000_0040}, '{1'b1, 9'h144, 32'h0000_0040},
    '{1'b0, 9'h148, 32'h0000_0000}, '{1'b0, 9'h1F0, 32'h0000_0000}, '{1'b1, 9'h10C, 32'hFFFF_FFFF},
    '{1'b0, 9'h10C, 32'h0000_0000}};
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  avmm_req_t   req     = '0;
  avmm_rsp_t   o_bus;
  logic        fpin    = 1'b0;
  logic [3:0]  sys_src = 4'h0;
  logic [29:0] srcs    = 30'h0000_0001;
  logic        normal_n, fast_n, wake, awake;
  logic [7:0]  n_ent, f_ent;
  logic [31:0] q;
  int          mismatches = 0;
  int          n_checks   = 0;
  int          cycles     = 0;
  always #50 i_clock = ~i_clock;
  vectored_interrupt_controller #(.SYSTEM_LINES(4), .EXTERNAL_MAP(32'h0000_0005)) u_vectored_interrupt_controller (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(req), .o_bus(o_bus), .i_fast_input_pin(fpin),
    .i_system_source(sys_src), .i_sources(srcs), .o_normal_request_n(normal_n),
    .o_fast_request_n(fast_n), .o_wake(wake));
  core_model u_core_model (.i_clock(i_clock), .i_normal_request_n(normal_n), .i_fast_request_n(fast_n),
    .o_normal_entries(n_ent), .o_fast_entries(f_ent), .o_awake(awake));
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
  endtask : step
  // one edge before raising keeps the release and the next request apart
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clock);
    req <= '{read: ~w, write: w, address: a, writedata: d};
    do begin
      @(posedge i_clock);
    end while (o_bus.waitrequest !== 1'b0);
    r = o_bus.readdata;
    req <= '0;
  endtask : bus
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0000_0000, r);
  endtask : rd
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      print_verdict();
    end
  end
  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial begin
    step(20);
    i_rst_n <= 1'b1;
    step(2);
    chk1(normal_n, 1'h1); chk1(fast_n, 1'h1); chk1(wake, 1'h0); chk1(o_bus.waitrequest, 1'h1);
    for (int i = 0; i < 25; i++) begin
      if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].d);
      else begin rd(ROWS[i].a, q); chk(q, ROWS[i].d); end
    end
    for (int n = 0; n < 9; n++) wr(OFS_VECTOR_BASE + 9'(n * 4), 32'hA000_0000 | n);
    rd(9'h0A0, q); chk(q, 32'hA000_0008);
    // external pin source 2, disabled, every trigger type
    for (int t = 0; t < 4; t++) begin
      srcs[0] <= ~t[1];
      wr(9'h008, {25'h0, 2'(t), 5'h00});
      wr(OFS_CLEAR, 32'h0000_0004);
      step(6); rd(OFS_PENDING, q); chk1(q[2], 1'h0);
      srcs[0] <= t[1];
      step(6); rd(OFS_PENDING, q); chk1(q[2], 1'h1);
      chk1(normal_n, 1'h1);
    end
    wr(OFS_CLEAR, 32'h0000_0004);
    // level source 3 in service, edge source 4 nests above it
    srcs[1] <= 1'b1;
    step(4); chk1(normal_n, 1'h0); chk1(wake, 1'h1); chk1(awake, 1'h1);
    rd(OFS_CORE_STATUS, q); chk1(q[CORE_NORMAL], 1'h1);
    rd(OFS_VECTOR, q); chk(q, 32'hA000_0003);
    step(3); chk1(normal_n, 1'h1);
    rd(OFS_CURRENT, q); chk(q, 32'h0000_0003);
    srcs[2] <= 1'b1;
    step(4); chk1(normal_n, 1'h0);
    rd(OFS_VECTOR, q); chk(q, 32'hA000_0004);
    rd(OFS_CURRENT, q); chk(q, 32'h0000_0004);
    rd(OFS_PENDING, q); chk(q[4:3], 2'h1);
    wr(OFS_END, 32'h0000_0000);
    rd(OFS_CURRENT, q); chk(q, 32'h0000_0003);
    wr(OFS_END, 32'h0000_0000);
    rd(OFS_CURRENT, q); chk(q, 32'h0000_0000);
    step(3); chk1(normal_n, 1'h0);
    srcs[1] <= 1'b0;
    step(4); chk1(normal_n, 1'h1);
    // set and clear commands
    wr(OFS_SET, 32'h0000_0008);
    rd(OFS_PENDING, q); chk1(q[3], 1'h0);
    wr(OFS_SET, 32'h0000_0010);
    rd(OFS_PENDING, q); chk1(q[4], 1'h1);
    wr(OFS_CLEAR, 32'h0000_0010);
    rd(OFS_PENDING, q); chk1(q[4], 1'h0);
    // protect mode keeps state across a vector read
    wr(OFS_DEBUG, 32'h0000_0001);
    wr(OFS_SET, 32'h0000_0010);
    rd(OFS_VECTOR, q); chk(q, 32'hA000_0004);
    rd(OFS_PENDING, q); chk1(q[4], 1'h1);
    rd(OFS_CURRENT, q); chk(q, 32'h0000_0000);
    wr(OFS_DEBUG, 32'h0000_0000);
    rd(OFS_VECTOR, q); chk(q, 32'hA000_0004);
    rd(OFS_PENDING, q); chk1(q[4], 1'h0);
    wr(OFS_END, 32'h0000_0000);
    // equal priority goes to the lower number
    wr(OFS_SET, 32'h0000_0180);
    rd(OFS_VECTOR, q); chk(q, 32'hA000_0007);
    wr(OFS_END, 32'h0000_0000);
    rd(OFS_VECTOR, q); chk(q, 32'hA000_0008);
    wr(OFS_END, 32'h0000_0000);
    // fast pin on source 0
    fpin <= 1'b1;
    step(6); chk1(fast_n, 1'h0); chk1(normal_n, 1'h1);
    rd(OFS_CORE_STATUS, q); chk1(q[CORE_FAST], 1'h1);
    rd(OFS_FAST_VECTOR, q); chk(q, 32'hA000_0000);
    step(3); chk1(fast_n, 1'h1);
    fpin <= 1'b0;
    // fast forcing of edge source 6
    wr(OFS_FF_ENABLE, 32'h0000_0040);
    srcs[4] <= 1'b1;
    step(4); chk1(fast_n, 1'h0); chk1(normal_n, 1'h1);
    rd(OFS_VECTOR, q); chk(q, 32'h0000_0000);
    rd(OFS_PENDING, q); chk1(q[6], 1'h1);
    wr(OFS_CLEAR, 32'h0000_0040);
    wr(OFS_FF_DISABLE, 32'h0000_0040);
    step(3); chk1(fast_n, 1'h1);
    // general mask: wake without a request line
    wr(OFS_DEBUG, 32'h0000_0002);
    srcs[1] <= 1'b1;
    step(4); chk1(wake, 1'h1); chk1(normal_n, 1'h1);
    srcs[1] <= 1'b0;
    wr(OFS_DEBUG, 32'h0000_0000);
    // disabled source 5 and system source 1 show only as pending
    srcs[3] <= 1'b1;
    sys_src <= 4'h4;
    step(4); rd(OFS_PENDING, q); chk(q[5:1], 5'h11);
    chk1(normal_n, 1'h1);
    chk({24'h0, f_ent}, 32'h0000_0002);
    chk({24'h0, n_ent}, 32'h0000_0007);
    print_verdict();
  end
endmodule : vectored_interrupt_controller_test
